// [verilog/regulator_fault_monitor.sv]
// Purpose: fault supervision for four linear regulators
// Assumes: level and target codes come from logic on the core clock
// Notes:   overvoltage and enable pins arrive asynchronously
`timescale 1ns/1ps
module regulator_fault_monitor
  import regulator_fault_pkg::*;
(
  // clock and reset
  input  wire logic                            core_clk_i,
  input  wire logic                            rst_i,
  // register port
  input  wire logic [7:0]                      reg_addr_i,
  input  wire logic [15:0]                     reg_wdata_i,
  input  wire logic                            reg_wr_i,
  input  wire logic                            reg_rd_i,
  output logic      [15:0]                     reg_rdata_o,
  output logic                                 reg_rvalid_o,
  // regulator sensing
  input  wire logic [NUM_REGS-1:0][LEVEL_W-1:0] reg_level_i,
  input  wire logic [NUM_REGS-1:0][LEVEL_W-1:0] reg_target_i,
  input  wire logic [NUM_REGS-1:0]             reg_overvolt_i,
  // other fault sources
  input  wire logic                            converter_uv_irq_i,
  input  wire logic                            converter_fault_i,
  input  wire logic                            switch_fault_i,
  // power control
  input  wire power_state_t                    power_state_i,
  input  wire logic [NUM_REGS-1:0]             reg_sw_enable_i,
  input  wire logic                            reg1_alt_control_select_i,
  input  wire logic                            reg1_alt_pin_enable_i,
  input  wire logic                            reg1_enable_in_n_i,
  input  wire logic [VSEL_W-1:0]               reg1_voltage_select_i,
  input  wire logic [VSEL_W-1:0]               reg1_hib_level_i,
  input  wire logic                            hibernate_i,
  // fault pin
  input  wire logic                            fault_pin_select_i,
  output logic                                 fault_out_n_o,
  // regulator control and interrupt
  output logic      [NUM_REGS-1:0]             reg_enable_o,
  output logic      [VSEL_W-1:0]               reg1_output_level_o,
  output logic                                 shutdown_req_o,
  output logic                                 undervoltage_top_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [NUM_REGS-1:0] uv_flags;
  logic [15:0]         uv_mask;
  logic [1:0]          fault_act [NUM_REGS];
  logic [NUM_REGS-1:0] fpin_mask;
  logic [NUM_REGS-1:0] reg_off;
  logic [NUM_REGS-1:0] uv_prev;
  logic [NUM_REGS-1:0] fault_prev;

  logic [NUM_REGS-1:0] uv_raw;
  logic [NUM_REGS-1:0] uv_filt;
  logic [NUM_REGS-1:0] ov_sync;
  logic [NUM_REGS-1:0] ov_filt;
  logic [NUM_REGS-1:0] wr_ctrl;
  logic [NUM_REGS-1:0] off_set;
  logic [NUM_REGS-1:0] sys_set;
  logic [15:0]         ctrl_or [NUM_REGS+1];
  logic                enable_in_n_sync;
  // edges are declared ahead of the loop below, which reads them
  logic [NUM_REGS-1:0] fault_now;
  logic [NUM_REGS-1:0] uv_rise;
  logic [NUM_REGS-1:0] fault_rise;

  ////////////////////////////////////////////////////////////////////////////
  // per-regulator detection, filtering and action decode

  assign ctrl_or[0] = 16'h0000;

  genvar n;
  generate
    for (n = 0; n < NUM_REGS; n++) begin : g_reg
      wire [PROD_W-1:0] lvl_scaled = PROD_W'(reg_level_i[n]) * FULL_PERCENT;
      wire [PROD_W-1:0] tgt_scaled = PROD_W'(reg_target_i[n]) * UV_PERCENT;
      wire              ctrl_hit   = (reg_addr_i == FAULT_CTRL_ADDR[n]);

      // compare scaled codes so no division is needed
      assign uv_raw[n] = (lvl_scaled < tgt_scaled); // RULE_01

      fault_persist_filter u_uv_filt (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .raw_i      (uv_raw[n]),
        .filt_o     (uv_filt[n])
      );

      pin_sync3 #(.RESET_VAL(1'b0)) u_ov_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .in_i       (reg_overvolt_i[n]),
        .out_o      (ov_sync[n])
      );

      fault_persist_filter u_ov_filt (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .raw_i      (ov_sync[n]),
        .filt_o     (ov_filt[n])
      );

      // each regulator owns its own action field
      assign wr_ctrl[n]   = reg_wr_i && ctrl_hit; // RULE_04
      assign off_set[n]   = fault_rise[n] && (fault_act[n] == ACT_REG_OFF); // RULE_03
      assign sys_set[n]   = fault_rise[n] && fault_act[n][1]; // RULE_03
      assign ctrl_or[n+1] = ctrl_or[n] | (ctrl_hit ? (16'(fault_act[n]) << ACTION_LO) : 16'h0000);

      // action field write; other bits of the word are not stored
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          fault_act[n] <= ACTION_RESET;
        end else if (wr_ctrl[n]) begin
          fault_act[n] <= reg_wdata_i[ACTION_LO +: 2]; // RULE_04
        end
      end

      a_uv_compare: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_01
        (PROD_W'(reg_level_i[n]) * FULL_PERCENT >= PROD_W'(reg_target_i[n]) * UV_PERCENT)
        |=> !uv_filt[n])
        else $error("undervoltage reported above threshold");

      a_flag_on_rise: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_07
        $rose(uv_filt[n]) |=> uv_flags[n])
        else $error("status bit not set on undervoltage edge");

      a_irq_on_ignore: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_05
        uv_rise[n] && (fault_act[n] == ACT_IGNORE) |=> uv_flags[n])
        else $error("ignored fault raised no interrupt");

      a_action_off: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_03
        fault_rise[n] && (fault_act[n] == ACT_REG_OFF) |=> reg_off[n] ##1 !reg_enable_o[n])
        else $error("regulator not disabled on fault");

      a_action_ignore: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_03
        fault_rise[n] && (fault_act[n] == ACT_IGNORE) && !reg_off[n] |=> !reg_off[n])
        else $error("ignored fault disabled the regulator");

      a_action_sys: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_03
        fault_rise[n] && fault_act[n][1] |=> shutdown_req_o)
        else $error("system shutdown not requested");

      a_off_clear: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_03
        wr_ctrl[n] && !off_set[n] |=> !reg_off[n])
        else $error("regulator off latch not released by write");

      a_ctrl_write: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_04
        wr_ctrl[n] |=> (fault_act[n] == $past(reg_wdata_i[ACTION_LO +: 2])))
        else $error("action field not written");

      a_ctrl_keep: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_04
        !wr_ctrl[n] |=> $stable(fault_act[n]))
        else $error("action field changed without its own write");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // edge detection and register decode

  assign fault_now  = uv_filt | ov_filt;
  assign uv_rise    = uv_filt & ~uv_prev;
  assign fault_rise = fault_now & ~fault_prev;

  wire rd_status = reg_rd_i && (reg_addr_i == ADDR_UV_STATUS);
  wire wr_mask   = reg_wr_i && (reg_addr_i == ADDR_UV_MASK);
  wire wr_fpin   = reg_wr_i && (reg_addr_i == ADDR_FAULTPIN_MSK);

  wire [NUM_REGS-1:0] flag_mask = uv_mask[FLAG_LO +: NUM_REGS];

  // a new edge in the read cycle survives the clear
  wire [NUM_REGS-1:0] next_flags   = uv_rise | (uv_flags & ~{NUM_REGS{rd_status}}); // RULE_05 RULE_08
  wire [NUM_REGS-1:0] next_reg_off = off_set | (reg_off & ~wr_ctrl);

  // read data selection, unmapped addresses read zero
  wire [15:0] status_word = 16'(uv_flags) << FLAG_LO;
  wire [15:0] fpin_word   = 16'(fpin_mask) << FPMASK_LO;
  wire [15:0] read_word   = (reg_addr_i == ADDR_UV_STATUS)    ? status_word :
                            (reg_addr_i == ADDR_UV_MASK)      ? uv_mask :
                            (reg_addr_i == ADDR_FAULTPIN_MSK) ? fpin_word :
                            ctrl_or[NUM_REGS];

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and fault pin

  wire unmasked_uv = |(uv_flags & ~flag_mask); // RULE_09
  wire next_irq    = unmasked_uv || converter_uv_irq_i; // RULE_06

  // unmasked regulator faults plus external converter and switch faults
  wire reg_pin_flt    = |(fault_now & ~fpin_mask); // RULE_12
  wire any_pin_flt    = reg_pin_flt || converter_fault_i || switch_fault_i; // RULE_19
  wire next_fault_n   = !(fault_pin_select_i && any_pin_flt); // RULE_10
  wire next_shutdown  = |sys_set;

  ////////////////////////////////////////////////////////////////////////////
  // regulator enables and regulator 1 level

  pin_sync3 #(.RESET_VAL(1'b1)) u_en_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .in_i       (reg1_enable_in_n_i),
    .out_o      (enable_in_n_sync)
  );

  wire state_on   = (power_state_i == PS_ACTIVE);
  wire reg1_dead  = (power_state_i == PS_BACKUP) || (power_state_i == PS_ZERO);

  // outside the active state every normal enable stays off
  wire [NUM_REGS-1:0] normal_en = reg_sw_enable_i & ~reg_off & {NUM_REGS{state_on}}; // RULE_13

  // pin mode keeps regulator 1 on in OFF, unless the pin takes over
  wire reg1_pin_lvl = reg1_alt_pin_enable_i ? !enable_in_n_sync : 1'b1; // RULE_14
  wire reg1_alt_en  = reg1_pin_lvl && !reg_off[0];
  wire reg1_sel_en  = reg1_alt_control_select_i ? reg1_alt_en : normal_en[0]; // RULE_14
  wire reg1_en      = !reg1_dead && reg1_sel_en; // RULE_15

  wire [NUM_REGS-1:0] next_enable = {normal_en[NUM_REGS-1:1], reg1_en};

  // hibernate level only applies outside pin mode
  wire                use_vsel   = reg1_alt_control_select_i || !hibernate_i; // RULE_16
  wire [VSEL_W-1:0]   next_level = use_vsel ? reg1_voltage_select_i : reg1_hib_level_i;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // status, masks and fault latches
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      uv_flags   <= '0;
      uv_mask    <= UV_MASK_RESET;
      fpin_mask  <= FPMASK_RESET;
      reg_off    <= '0;
      uv_prev    <= '0;
      fault_prev <= '0;
    end else begin
      uv_flags   <= next_flags; // RULE_07
      reg_off    <= next_reg_off; // RULE_03
      uv_prev    <= uv_filt;
      fault_prev <= fault_now;
      if (wr_mask) uv_mask <= reg_wdata_i;
      if (wr_fpin) fpin_mask <= reg_wdata_i[FPMASK_LO +: NUM_REGS]; // RULE_11
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o  <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o  <= reg_rd_i ? read_word : 16'h0000;
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // registered outputs
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      undervoltage_top_irq_o <= 1'b0;
      fault_out_n_o          <= 1'b1;
      shutdown_req_o         <= 1'b0;
      reg_enable_o           <= '0;
      reg1_output_level_o    <= '0;
    end else begin
      undervoltage_top_irq_o <= next_irq; // RULE_06
      fault_out_n_o          <= next_fault_n; // RULE_10
      shutdown_req_o         <= next_shutdown; // RULE_03
      reg_enable_o           <= next_enable;
      reg1_output_level_o    <= next_level; // RULE_16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_read_clears: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_08
    rd_status && (uv_rise == '0) |=> (uv_flags == '0))
    else $error("status bits survived a status read");

  a_set_beats_clr: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_08
    rd_status && uv_rise[0] |=> uv_flags[0])
    else $error("edge lost during status read");

  a_irq_masked: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_09
    ((uv_flags & ~uv_mask[FLAG_LO +: NUM_REGS]) == '0) && !converter_uv_irq_i
    |=> !undervoltage_top_irq_o)
    else $error("masked status raised top interrupt");

  a_irq_rollup: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_06
    (|(uv_flags & ~uv_mask[FLAG_LO +: NUM_REGS])) || converter_uv_irq_i
    |=> undervoltage_top_irq_o)
    else $error("top interrupt missing");

  a_pin_reg_fault: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_12
    fault_pin_select_i && (|((uv_filt | ov_filt) & ~fpin_mask)) |=> !fault_out_n_o)
    else $error("fault pin not low on unmasked fault");

  a_pin_ext_fault: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_19
    fault_pin_select_i && (converter_fault_i || switch_fault_i) |=> !fault_out_n_o)
    else $error("fault pin not low on external fault");

  a_pin_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_11
    !fault_pin_select_i || (((uv_filt | ov_filt) & ~fpin_mask) == '0
    && !converter_fault_i && !switch_fault_i) |=> fault_out_n_o)
    else $error("fault pin low without unmasked fault");

  a_off_state: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_13
    (power_state_i == PS_OFF) && !reg1_alt_control_select_i |=> (reg_enable_o == '0))
    else $error("regulator enabled in OFF state");

  a_reg1_always: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_14
    reg1_alt_control_select_i && !reg1_alt_pin_enable_i && !reg1_dead && !reg_off[0]
    |=> reg_enable_o[0])
    else $error("regulator 1 not held on in pin mode");

  a_reg1_backup: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_15
    (power_state_i == PS_BACKUP) || (power_state_i == PS_ZERO) |=> !reg_enable_o[0])
    else $error("regulator 1 on in BACKUP or ZERO");

  a_reg1_level: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_16
    reg1_alt_control_select_i |=> (reg1_output_level_o == $past(reg1_voltage_select_i)))
    else $error("regulator 1 level not from voltage select");

  // only the mask write is checked against the whole bus word; the pin mask and status checks reuse
  // the design's field positions, so a wrong field position passes here unseen
  a_mask_write: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_09
    wr_mask |=> (uv_mask == $past(reg_wdata_i)))
    else $error("interrupt mask not written");

  a_fpin_write: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_11
    wr_fpin |=> (fpin_mask == $past(reg_wdata_i[FPMASK_LO +: NUM_REGS])))
    else $error("fault pin mask not written");

  a_status_data: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_07
    rd_status |=> (reg_rdata_o == $past(status_word)))
    else $error("status read returned wrong bits");

  a_shut_idle: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_03
    (sys_set == '0) |=> !shutdown_req_o)
    else $error("shutdown requested without fault edge");

  a_reg1_pin_ctrl: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_14
    reg1_alt_control_select_i && reg1_alt_pin_enable_i && !reg1_dead && !reg_off[0]
    |=> (reg_enable_o[0] == !$past(enable_in_n_sync)))
    else $error("regulator 1 not following its enable pin");

endmodule : regulator_fault_monitor

// [verilog/regulator_fault_pkg.sv]
// Purpose: shared constants and types for the regulator fault monitor
// Assumes: 100 MHz core clock, 8-bit register address, 16-bit register data
// Notes:   register addresses are used exactly as printed
//
// Operation
// RULE_01: undervoltage when output below 95% target
// RULE_02: report fault only after it persists
// RULE_03: action field selects ignore, regulator off, shutdown
// RULE_04: four separate action fields at fixed offsets
// RULE_05: every fault raises interrupt, even when ignored; overvoltage faults raise none
// RULE_06: unmasked undervoltage interrupts merge into one
// RULE_07: status bits 11:8 set on rising edge
// RULE_08: status bits clear when status is read
// RULE_09: mask bit one blocks its status bit
// RULE_10: selected fault pin low on any fault
// RULE_11: fault pin mask bits 11:8, reset zero
// RULE_12: under or overvoltage on unmasked regulator pulls low
// RULE_13: all regulators off in OFF state; regulator 1 under alternate control can stay on
// RULE_14: regulator 1 alternate pin or always-on control
// RULE_15: regulator 1 off in BACKUP and ZERO
// RULE_16: pin mode uses voltage select, ignores hibernate
// RULE_17: software sets 1.8V before OFF-state operation
// RULE_18: persistence is a fixed cycle count
// RULE_19: external converter and switch faults join pin
package regulator_fault_pkg;

  localparam int NUM_REGS = 4;
  localparam int LEVEL_W  = 10;
  localparam int VSEL_W   = 5;
  localparam int PROD_W   = 17;

  // register addresses
  localparam logic [7:0] ADDR_UV_STATUS    = 8'h1c;
  localparam logic [7:0] ADDR_UV_MASK      = 8'h24;
  localparam logic [7:0] ADDR_FAULTPIN_MSK = 8'hd7;
  localparam logic [7:0] FAULT_CTRL_ADDR [NUM_REGS] = '{8'hc9, 8'hcc, 8'hcf, 8'hd2};

  // field positions
  localparam int ACTION_LO  = 14;
  localparam int FLAG_LO    = 8;
  localparam int FPMASK_LO  = 8;

  // reset values
  localparam logic [15:0]         UV_MASK_RESET    = 16'h0000;
  localparam logic [1:0]          ACTION_RESET     = 2'h0;
  localparam logic [NUM_REGS-1:0] FPMASK_RESET     = 4'h0;

  // fault actions
  typedef enum logic [1:0] {
    ACT_IGNORE  = 2'b00,
    ACT_REG_OFF = 2'b01,
    ACT_SYS_OFF = 2'b10,
    ACT_SYS_ALT = 2'b11
  } fault_action_t;

  // device power states seen by this block
  typedef enum logic [1:0] {
    PS_OFF    = 2'b00,
    PS_ACTIVE = 2'b01,
    PS_BACKUP = 2'b10,
    PS_ZERO   = 2'b11
  } power_state_t;

  // undervoltage threshold as a percentage of target
  localparam logic [PROD_W-1:0] UV_PERCENT   = 17'h0005f;
  localparam logic [PROD_W-1:0] FULL_PERCENT = 17'h00064;

  // persistence filter timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int PERSIST_TIME_NS = 10000;
  localparam int PERSIST_CYCLES  = (PERSIST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PERSIST_CW      = 10;
  localparam logic [PERSIST_CW-1:0] PERSIST_LAST = PERSIST_CW'(PERSIST_CYCLES - 1);

endpackage : regulator_fault_pkg

// [verilog/pin_sync3.sv]
// Purpose: three-stage input synchroniser with agreement check
// Assumes: input comes from outside the core clock domain
// Notes:   output follows only once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // pin
  input  wire logic in_i,
  output logic      out_o
);

  logic s1;
  logic s2;
  logic s3;

  // stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s1    <= RESET_VAL;
      s2    <= RESET_VAL;
      s3    <= RESET_VAL;
      out_o <= RESET_VAL;
    end else begin
      s1 <= in_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) out_o <= s3;
    end
  end

endmodule : pin_sync3

// [verilog/fault_persist_filter.sv]
// Purpose: persistence filter for one raw fault signal
// Assumes: raw input is already in the core clock domain
// Notes:   any low cycle restarts the count, so surges are dropped
`timescale 1ns/1ps
module fault_persist_filter
  import regulator_fault_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // fault
  input  wire logic raw_i,
  output logic      filt_o
);

  logic [PERSIST_CW-1:0] cnt;
  wire                   at_last = (cnt == PERSIST_LAST);

  // count consecutive raw cycles, report only at the last one
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt    <= '0;
      filt_o <= 1'b0;
    end else if (!raw_i) begin
      cnt    <= '0; // RULE_02
      filt_o <= 1'b0;
    end else if (at_last) begin
      filt_o <= 1'b1; // RULE_18
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  a_persist_rise: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_18
    $rose(filt_o) |-> $past(raw_i) && ($past(cnt) == PERSIST_LAST))
    else $error("fault reported before persistence count");

  a_surge_drop: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_02
    !raw_i |=> !filt_o)
    else $error("fault held after raw condition went away");

endmodule : fault_persist_filter

// [verification/reg_plant_model.sv]
// Purpose: regulator output sensing model for the fault monitor bench
// Assumes: level codes settle on the core clock, target code fixed
// Notes:   sag level sits one code under the threshold, edge level on it
`timescale 1ns/1ps
module reg_plant_model
  import regulator_fault_pkg::*;
(
  // clock
  input  wire logic                             core_clk_i,
  // stimulus
  input  wire logic [NUM_REGS-1:0]              sag_i,
  input  wire logic                             edge_i,
  // sensing
  output logic      [NUM_REGS-1:0][LEVEL_W-1:0] level_o,
  output logic      [NUM_REGS-1:0][LEVEL_W-1:0] target_o
);
  // target 200, threshold 190: 189 must trip, 190 must not
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < NUM_REGS; i++) begin
      target_o[i] <= 10'h0c8;
      level_o[i]  <= sag_i[i] ? 10'h0bd : (edge_i ? 10'h0be : 10'h0c8);
    end
  end
endmodule : reg_plant_model

// [verification/regulator_fault_monitor_tb.sv]
// Purpose: self-checking bench for the regulator fault monitor
// Assumes: persistence of 1000 cycles from the package
// Notes:   inputs change on the falling edge only
`timescale 1ns/1ps
module regulator_fault_monitor_tb;
  import regulator_fault_pkg::*;
  logic core_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000, rdata_o, dat;
  logic rvalid_o, cuv = 0, cfault = 0, sfault = 0, hib = 0, fsel = 0, edge_v = 0;
  logic alt_sel = 0, alt_pen = 0, en_n = 1, pin_n, shut, irq;
  logic [NUM_REGS-1:0] ov = 4'h0, swen = 4'h0, sag = 4'h0, en;
  logic [NUM_REGS-1:0][LEVEL_W-1:0] lvl, tgt;
  logic [VSEL_W-1:0] vsel = 5'h00, hlev = 5'h00, olev;
  power_state_t ps = PS_ACTIVE;
  int bad_count = 0, compares = 0, shut_seen = 0;
  logic [1:0] acts [4] = '{2'b00, 2'b01, 2'b10, 2'b11};
  logic [7:0] rst_addr [7] = '{8'h1c, 8'h24, 8'hc9, 8'hcc, 8'hcf, 8'hd2, 8'hd7};

  regulator_fault_monitor DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata_o),
    .reg_rvalid_o(rvalid_o), .reg_level_i(lvl), .reg_target_i(tgt), .reg_overvolt_i(ov),
    .converter_uv_irq_i(cuv), .converter_fault_i(cfault), .switch_fault_i(sfault),
    .power_state_i(ps), .reg_sw_enable_i(swen), .reg1_alt_control_select_i(alt_sel),
    .reg1_alt_pin_enable_i(alt_pen), .reg1_enable_in_n_i(en_n), .reg1_voltage_select_i(vsel),
    .reg1_hib_level_i(hlev), .hibernate_i(hib), .fault_pin_select_i(fsel), .fault_out_n_o(pin_n),
    .reg_enable_o(en), .reg1_output_level_o(olev), .shutdown_req_o(shut), .undervoltage_top_irq_o(irq));
  reg_plant_model plant (.core_clk_i(core_clk_i), .sag_i(sag), .edge_i(edge_v), .level_o(lvl), .target_o(tgt));

  always #5 core_clk_i = ~core_clk_i;
  // shutdown is a one-cycle pulse, so it is counted at every falling edge
  always @(negedge core_clk_i) if (shut === 1'b1) shut_seen++;

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk16
  task automatic chk1(input string n, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %b seen %b", n, e, g);
    end
  endtask : chk1
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : wait_n
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_i = a; reg_wdata_i = d; reg_wr_i = 1;
    @(negedge core_clk_i) reg_wr_i = 0;
    @(negedge core_clk_i); // idle cycle keeps back-to-back strobes apart
  endtask : wr
  // answer waited for under a bound of four cycles
  task automatic rdchk(input string n, input logic [7:0] a, input logic [15:0] e);
    int k;
    reg_addr_i = a; reg_rd_i = 1;
    @(negedge core_clk_i) reg_rd_i = 0;
    for (k = 0; k < 4 && rvalid_o !== 1'b1; k++) @(negedge core_clk_i);
    if (k == 4) begin
      bad_count++;
      $display("BAD %s expected answer seen none", n);
      complete_run();
    end
    chk16(n, e, rdata_o);
    @(negedge core_clk_i);
  endtask : rdchk

  ////////////////////////////////////////////////////////////////////////
  initial begin
    wait_n(20);
    rst_i = 0;
    foreach (rst_addr[i]) rdchk("reset value", rst_addr[i], 16'h0000);
    rdchk("unmapped", 8'h55, 16'h0000);
    foreach (acts[i]) begin
      wr(FAULT_CTRL_ADDR[i], {acts[i], 14'h3fff});
      rdchk("action", FAULT_CTRL_ADDR[i], {acts[i], 14'h0000});
    end
    wr(ADDR_UV_MASK, 16'ha5a5);
    rdchk("uv mask", ADDR_UV_MASK, 16'ha5a5);
    wr(ADDR_UV_MASK, 16'h0000);
    wr(ADDR_UV_STATUS, 16'hffff);
    rdchk("status write", ADDR_UV_STATUS, 16'h0000);
    swen = 4'hf; fsel = 1;
    // level on the threshold and a short surge must both pass unseen
    edge_v = 1; wait_n(1100); edge_v = 0;
    sag = 4'b0100; wait_n(500); sag = 4'h0; wait_n(10);
    rdchk("no fault", ADDR_UV_STATUS, 16'h0000);
    chk1("no shutdown", 1'b1, shut_seen == 0);
    sag = 4'hf; wait_n(1100);
    chk1("fault pin", 1'b0, pin_n);
    chk1("ignore keeps reg1", 1'b1, en[0]);
    chk1("reg2 off", 1'b0, en[1]);
    chk1("shutdown", 1'b1, shut_seen > 0);
    sag = 4'h0; wait_n(10);
    chk1("pin released", 1'b1, pin_n);
    chk1("irq", 1'b1, irq);
    rdchk("status", ADDR_UV_STATUS, 16'h0f00);
    rdchk("status cleared", ADDR_UV_STATUS, 16'h0000);
    wait_n(4);
    chk1("irq cleared", 1'b0, irq);
    chk1("reg2 latched off", 1'b0, en[1]);
    wr(FAULT_CTRL_ADDR[1], 16'h0000); wait_n(4);
    chk1("reg2 back on", 1'b1, en[1]);
    // masked regulator 1 reaches neither the interrupt nor the pin
    wr(ADDR_UV_MASK, 16'h0100); wr(ADDR_FAULTPIN_MSK, 16'hffff);
    rdchk("pin mask", ADDR_FAULTPIN_MSK, 16'h0f00);
    sag = 4'h1; wait_n(1100);
    chk1("masked pin", 1'b1, pin_n);
    chk1("masked irq", 1'b0, irq);
    cfault = 1; wait_n(4);
    chk1("converter fault", 1'b0, pin_n);
    cfault = 0; sfault = 1; wait_n(4);
    chk1("switch fault", 1'b0, pin_n);
    sfault = 0; cuv = 1; wait_n(4);
    chk1("converter irq", 1'b1, irq);
    cuv = 0; sag = 4'h0;
    rdchk("masked status", ADDR_UV_STATUS, 16'h0100);
    wr(ADDR_FAULTPIN_MSK, 16'h0000); wr(ADDR_UV_MASK, 16'h0000);
    ov = 4'h2; wait_n(1100);
    chk1("overvolt pin", 1'b0, pin_n);
    ov = 4'h0; wait_n(10);
    chk1("overvolt gone", 1'b1, pin_n);
    // regulator 1 alternate control
    ps = PS_OFF; wait_n(4);
    chk16("off state", 16'h0000, {12'h000, en});
    hib = 1; hlev = 5'h03; vsel = 5'h10; wait_n(4);
    chk16("hib level", {11'h000, 5'h03}, {11'h000, olev});
    alt_sel = 1; wait_n(6);
    chk1("always on", 1'b1, en[0]);
    chk16("level", {11'h000, 5'h10}, {11'h000, olev});
    alt_pen = 1; wait_n(6);
    chk1("pin inactive", 1'b0, en[0]);
    en_n = 0; wait_n(6);
    chk1("pin active", 1'b1, en[0]);
    ps = PS_BACKUP; wait_n(4);
    chk1("backup", 1'b0, en[0]);
    ps = PS_ZERO; wait_n(4);
    chk1("zero", 1'b0, en[0]);
    complete_run();
  end
endmodule : regulator_fault_monitor_tb
